// *** design/rrs_pkg.sv ***
// Constants, field layout and types shared by the rail ramp supervisor
package rrs_pkg;

	// Clock and tick timing
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int RAMP_RATE_HZ = 10_000;
	localparam int RAMP_TICK_CYC = SYS_CLK_HZ / RAMP_RATE_HZ;
	localparam int MON_PERIOD_NS = 100_000;
	localparam int MON_TICK_CYC = MON_PERIOD_NS / CLK_PERIOD_NS;
	localparam int AVG_INTERVAL_NS = 100_000_000;
	localparam int AVG_SAMPLES = AVG_INTERVAL_NS / MON_PERIOD_NS;
	localparam int SMOOTH_TAU_MS = 1550;
	localparam int SMOOTH_SHIFT =
		$clog2(SMOOTH_TAU_MS * 1_000_000 / AVG_INTERVAL_NS);

	// Data widths and fixed-point formats
	localparam int ADC_BITS = 12;
	localparam int AUX_BITS = 16;
	localparam int AUX_CHANNELS = 4;
	localparam int TEMP_CHANNELS = 2;
	localparam int VIN_CHANNEL = 3;
	localparam int VIN_SCALE_FRAC = 12;
	localparam int AVG_RECIP_SHIFT = 20;
	localparam int AVG_RECIP =
		(2 ** (AVG_RECIP_SHIFT + AUX_BITS - ADC_BITS)) / AVG_SAMPLES;
	localparam logic [31:0] FOLD_STEP = 32'h0001_0000;

	// Writable configuration words, byte address = index * 4
	localparam int CFG_CTRL = 0;
	localparam int CFG_VOUT = 1;
	localparam int CFG_TON_DELAY = 2;
	localparam int CFG_TON_RISE = 3;
	localparam int CFG_TOFF_FALL = 4;
	localparam int CFG_OC_LIMIT = 5;
	localparam int CFG_OC_LV = 6;
	localparam int CFG_VIN_SCALE = 7;
	localparam int CFG_VIN_OV = 8;
	localparam int CFG_VIN_UV = 9;
	localparam int CFG_VIN_ON = 10;
	localparam int CFG_VIN_OFF = 11;
	localparam int CFG_MIN_PULSE = 12;
	localparam int CFG_OT_LIMIT = 13;
	localparam int CFG_LIGHT_LOAD = 14;
	localparam int CFG_COUNT = 15;
	localparam logic [15:0] CFG_RST [CFG_COUNT] = '{
		16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
		16'hffff, 16'h0000, 16'h1000, 16'hffff, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0000};

	// Read-only and clear-on-write register addresses
	localparam logic [7:0] REG_CFG_END = 8'h3c;
	localparam logic [7:0] REG_STATUS = 8'h3c;
	localparam logic [7:0] REG_STATE = 8'h40;
	localparam logic [7:0] REG_VIN = 8'h44;
	localparam logic [7:0] REG_REF = 8'h48;
	localparam logic [7:0] REG_DUTY = 8'h4c;
	localparam logic [7:0] REG_AUX0 = 8'h50;
	localparam logic [7:0] REG_AUX3 = 8'h5c;
	localparam logic [7:0] REG_TEMP0 = 8'h60;
	localparam logic [7:0] REG_TEMPERATURE_INPUT_ONE = 8'h64;

	// Control word fields
	localparam int CTRL_ON_BIT = 0;
	localparam int CTRL_UV_RESP_LSB = 1;
	localparam int CTRL_OC_RESP_LSB = 3;
	localparam int CTRL_OT_EN_BIT = 5;

	// Sticky status bits
	localparam int ST_VIN_OV = 0;
	localparam int ST_VIN_UV = 1;
	localparam int ST_FOLDBACK = 2;
	localparam int ST_OC_LV = 3;
	localparam int ST_OVER_TEMP = 4;
	localparam int STATUS_BITS = 5;

	typedef enum logic [1:0] {
		RESP_CONTINUE = 2'b00,
		RESP_CONT_DELAY = 2'b01,
		RESP_SHUTDOWN = 2'b10,
		RESP_SHUTDOWN_ALT = 2'b11
	} rrs_resp_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_DELAY = 3'b001,
		S_RISE = 3'b010,
		S_REGULATE = 3'b011,
		S_FALL = 3'b100,
		S_OFF = 3'b101
	} rrs_state_t;

	typedef enum logic [1:0] {
		BANK_RAMP = 2'b00,
		BANK_NORMAL = 2'b01,
		BANK_LIGHT = 2'b10
	} rrs_bank_t;

	typedef enum logic [1:0] {
		DIV_DUTY = 2'b00,
		DIV_RISE = 2'b01,
		DIV_FALL = 2'b10
	} rrs_div_t;

endpackage

// *** design/rrs_mon_if.sv ***
// Monitor sample path between the supervisor and the averaging unit
`timescale 1ns/1ps
`default_nettype none
interface rrs_mon_if;
	import rrs_pkg::*;
	logic sampleTick;
	logic [ADC_BITS-1:0] code [AUX_CHANNELS];
	logic [AUX_BITS-1:0] auxAvg [AUX_CHANNELS];
	logic [AUX_BITS-1:0] tempSmooth [TEMP_CHANNELS];
	modport sup (output sampleTick, output code,
		input auxAvg, input tempSmooth);
	modport filt (input sampleTick, input code,
		output auxAvg, output tempSmooth);
endinterface
`default_nettype wire

// *** design/rrs_aux_avg.sv ***
// Running-sum averaging of monitor samples and temperature smoothing
`timescale 1ns/1ps
`default_nettype none
module rrs_aux_avg #(
	parameter int SAMPLES = rrs_pkg::AVG_SAMPLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	rrs_mon_if.filt mon
);
	import rrs_pkg::*;

	// Reciprocal follows the sample count so a short interval still scales
	localparam int RECIP =
		(2 ** (AVG_RECIP_SHIFT + AUX_BITS - ADC_BITS)) / SAMPLES;

	logic [9:0] sampleCnt;
	logic lastSample;
	logic avgDone;

	assign lastSample = (sampleCnt == 10'(SAMPLES - 1));

	// Sample counter marks the end of each averaging interval
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			sampleCnt <= 10'h000;
			avgDone <= 1'b0;
		end
		else
		begin
			avgDone <= mon.sampleTick && lastSample;
			if (mon.sampleTick)
				sampleCnt <= lastSample ? 10'h000 : sampleCnt + 10'h001;
		end

	genvar ch;
	generate
		for (ch = 0; ch < AUX_CHANNELS; ch++)
		begin : g_chan
			logic [21:0] sum;
			logic [21:0] sumNow;
			logic [36:0] prod;
			logic [AUX_BITS-1:0] avg;

			assign sumNow = sum + 22'(mon.code[ch]);
			assign prod = 37'(sumNow) * 37'(RECIP);
			// add every 100us, average and restart each 100ms
			always_ff @(posedge sys_clk or negedge nrst)
				if (!nrst)
				begin
					sum <= 22'h000000;
					avg <= 16'h0000;
				end
				else if (mon.sampleTick)
				begin
					sum <= lastSample ? 22'h000000 : sumNow;
					// linear 16-bit code, no gain or offset
					if (lastSample)
						avg <= (|prod[36:36]) ? 16'hffff :
							prod[35:20];
				end
			// one averaged word per auxiliary input
			assign mon.auxAvg[ch] = avg;

			if (ch < TEMP_CHANNELS)
			begin : g_smooth
				logic [AUX_BITS-1:0] smooth;
				logic signed [AUX_BITS:0] diff;
				assign diff = $signed({1'b0, avg}) - $signed({1'b0, smooth});
				// first-order filter, 1.55 s time constant
				always_ff @(posedge sys_clk or negedge nrst)
					if (!nrst)
						smooth <= 16'h0000;
					else if (avgDone)
						smooth <= 16'(smooth + 16'(diff >>> SMOOTH_SHIFT));
				assign mon.tempSmooth[ch] = smooth;
			end
		end
	endgenerate

endmodule // rrs_aux_avg
`default_nettype wire

// *** design/rrs_supervisor.sv ***
// Rail ramp supervisor: soft start/stop, foldback, input and temp guard
//
// Contract
// - Output current above the fault limit lowers the reference, indefinitely; the code does this only in S_REGULATE, not during rise or fall.
// - In foldback, output below the low-voltage limit applies its response.
// - Input sense is a 12-bit 0..2.5V code times a programmable scale.
// - Scaled input is compared to separate over and under-voltage limits.
// - Input below turn-off starts a soft stop; turn-on is the upper level.
// - Input below the under-voltage limit applies the programmed response.
// - Continue responses keep running and finish the soft stop in progress.
// - Immediate-shutdown response disables the pulse-width output at once.
// - Temperature samples summed every 100us, averaged and restarted each 100ms.
// - Averaged temperature is smoothed with a 1.55 s time constant.
// - Auxiliary read returns four 16-bit averaged values, one per input.
// - Auxiliary codes are linear 0..65535 for 0..2.5V, no trim.
// - Ramp, normal and light-load modes select separate gain banks.
// - Turn-on waits the delay, then ramps at a rate from rise time.
// - Pulse output starts when ramp reaches pre-bias and duty exceeds minimum.
// - Idle keeps pulses off and the reference tracks the feedback voltage.
// - Pre-bias start duty is measured output divided by input voltage.
// - Ramp steps at 10 kHz with step sizes from rise or fall time.
// - Command to regulation equals delay plus rise regardless of pre-bias.
// - On error converter saturation, step reference to reduce the error; the code does this only in S_RISE, and in S_FALL for negative saturation.
// - After saturation the ramp resumes from the adjusted set point.
`timescale 1ns/1ps
`default_nettype none
module rrs_supervisor #(
	parameter int AVG_N = rrs_pkg::AVG_SAMPLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] busAddr,
	input wire logic [31:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	output logic [31:0] busRdData,
	input wire logic [3:0][rrs_pkg::ADC_BITS-1:0] auxCode,
	input wire logic [15:0] ioutMeas,
	input wire logic [15:0] voutMeas,
	input wire logic errSatPos,
	input wire logic errSatNeg,
	output logic pwmEnable,
	output logic [15:0] refDac,
	output rrs_pkg::rrs_bank_t gainBank,
	output logic [15:0] startDuty
);
	import rrs_pkg::*;

	logic [15:0] cfg [CFG_COUNT];
	rrs_state_t state;
	logic [11:0] rampCnt;
	logic [11:0] monCnt;
	logic rampTick;
	logic monTick;
	logic [15:0] vinScaled;
	logic [27:0] vinProd;
	logic [31:0] minRefProd;
	logic [15:0] minRef;
	logic [31:0] refAcc;
	logic [31:0] targetQ;
	logic [32:0] riseSum;
	logic [32:0] satUp;
	logic [31:0] stepRise;
	logic [31:0] stepFall;
	logic [31:0] stepNow;
	logic [15:0] prebias;
	logic [15:0] delayCnt;
	logic [15:0] refNow;
	logic [STATUS_BITS-1:0] status;
	logic [STATUS_BITS-1:0] statusSet;
	rrs_resp_t uvResp;
	rrs_resp_t ocResp;
	logic railOn;
	logic uvFault;
	logic ovFault;
	logic overTemp;
	logic foldActive;
	logic ocLvTrip;
	logic shutNow;
	logic stopReq;
	logic goOn;
	logic divBusy;
	logic [5:0] divCnt;
	logic [15:0] divRem;
	logic [31:0] divQuo;
	logic [15:0] divDen;
	rrs_div_t divKind;
	logic [16:0] divTrial;
	logic divGe;
	logic [31:0] divResult;
	logic divStart;
	rrs_div_t divStartKind;
	logic [31:0] divNum;
	logic [15:0] divDenIn;

	rrs_mon_if mon ();

	rrs_aux_avg #(
		.SAMPLES(AVG_N)
	) u_avg (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.mon(mon.filt)
	);

	// Monitor channels feed the averaging unit
	assign mon.sampleTick = monTick;
	generate
		for (genvar ch = 0; ch < AUX_CHANNELS; ch++)
		begin : g_code
			assign mon.code[ch] = auxCode[ch];
		end
	endgenerate

	// Control fields and live comparisons
	assign railOn = cfg[CFG_CTRL][CTRL_ON_BIT];
	assign uvResp = rrs_resp_t'(cfg[CFG_CTRL][CTRL_UV_RESP_LSB +: 2]);
	assign ocResp = rrs_resp_t'(cfg[CFG_CTRL][CTRL_OC_RESP_LSB +: 2]);
	assign refNow = refAcc[31:16];
	assign targetQ = {cfg[CFG_VOUT], 16'h0000};
	// 12-bit sense code times the scale factor
	assign vinProd = 28'(auxCode[VIN_CHANNEL]) * 28'(cfg[CFG_VIN_SCALE]);
	assign minRefProd = 32'(cfg[CFG_MIN_PULSE]) * 32'(vinScaled);
	assign minRef = minRefProd[31:16];
	assign ovFault = vinScaled > cfg[CFG_VIN_OV];
	assign uvFault = vinScaled < cfg[CFG_VIN_UV];
	assign overTemp = cfg[CFG_CTRL][CTRL_OT_EN_BIT] &&
		((mon.tempSmooth[0] > cfg[CFG_OT_LIMIT]) ||
		(mon.tempSmooth[1] > cfg[CFG_OT_LIMIT]));
	assign foldActive = (state == S_REGULATE) && (ioutMeas > cfg[CFG_OC_LIMIT]);
	assign ocLvTrip = foldActive && (voutMeas < cfg[CFG_OC_LV]);
	// shutdown codes stop conversion at once
	assign shutNow = (uvFault && uvResp[1]) || (ocLvTrip && ocResp[1]);
	// turn-off threshold or under-voltage starts a soft stop
	assign stopReq = !railOn || (vinScaled < cfg[CFG_VIN_OFF]) ||
		uvFault || overTemp;
	assign goOn = railOn && (vinScaled >= cfg[CFG_VIN_ON]) && !uvFault;
	assign stepNow = (state == S_FALL) ? stepFall : stepRise;
	assign riseSum = {1'b0, refAcc} + {1'b0, stepRise};
	assign satUp = {1'b0, refAcc} + {1'b0, stepNow};

	// Ramp and monitor tick dividers
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			rampCnt <= 12'h000;
			monCnt <= 12'h000;
			rampTick <= 1'b0;
			monTick <= 1'b0;
		end
		else
		begin
			// fixed 10 kHz reference update rate
			rampTick <= (rampCnt == 12'(RAMP_TICK_CYC - 1));
			rampCnt <= (rampCnt == 12'(RAMP_TICK_CYC - 1)) ? 12'h000 :
				rampCnt + 12'h001;
			monTick <= (monCnt == 12'(MON_TICK_CYC - 1));
			monCnt <= (monCnt == 12'(MON_TICK_CYC - 1)) ? 12'h000 :
				monCnt + 12'h001;
		end

	// scaled input voltage captured at each monitor sample
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			vinScaled <= 16'h0000;
		else if (monTick)
			vinScaled <= vinProd[VIN_SCALE_FRAC +: 16];

	// Divider requests: rise step, fall step or pre-bias duty
	always_comb
	begin
		divStart = 1'b0;
		divStartKind = DIV_DUTY;
		divNum = {voutMeas, 16'h0000};
		divDenIn = vinScaled;
		if (state == S_IDLE && goOn)
		begin
			divStart = 1'b1;
			divStartKind = DIV_RISE;
			divNum = targetQ;
			divDenIn = cfg[CFG_TON_RISE];
		end
		else if ((state == S_RISE || state == S_REGULATE) && stopReq)
		begin
			divStart = 1'b1;
			divStartKind = DIV_FALL;
			divNum = refAcc;
			divDenIn = cfg[CFG_TOFF_FALL];
		end
		else if (state == S_IDLE && !divBusy)
			divStart = 1'b1;
		if (divDenIn == 16'h0000)
			divDenIn = 16'h0001;
	end

	assign divTrial = {divRem, divQuo[31]};
	assign divGe = divTrial >= {1'b0, divDen};
	assign divResult = {divQuo[30:0], divGe};

	// Serial restoring divider, 32 cycles per quotient
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			divBusy <= 1'b0;
			divCnt <= 6'h00;
			divRem <= 16'h0000;
			divQuo <= 32'h0000_0000;
			divDen <= 16'h0001;
			divKind <= DIV_DUTY;
		end
		else if (divStart)
		begin
			divBusy <= 1'b1;
			divCnt <= 6'h00;
			divRem <= 16'h0000;
			divQuo <= divNum;
			divDen <= divDenIn;
			divKind <= divStartKind;
		end
		else if (divBusy)
		begin
			divRem <= divGe ? 16'(divTrial - {1'b0, divDen}) : divTrial[15:0];
			divQuo <= divResult;
			divCnt <= divCnt + 6'h01;
			divBusy <= (divCnt != 6'h1f);
		end

	// Quotients land in step sizes or the pre-bias duty
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			stepRise <= 32'h0000_0000;
			stepFall <= 32'h0000_0000;
			startDuty <= 16'h0000;
		end
		else if (divBusy && divCnt == 6'h1f && !divStart)
			case (divKind)
				// rise step from target and rise time
				DIV_RISE: stepRise <= divResult;
				// fall step from present level and fall time
				DIV_FALL: stepFall <= divResult;
				// duty is output voltage over input voltage
				DIV_DUTY: startDuty <= (|divResult[31:16]) ? 16'hffff :
					divResult[15:0];
				default: startDuty <= startDuty;
			endcase

	// Rail sequencing state machine
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			state <= S_IDLE;
			refAcc <= 32'h0000_0000;
			delayCnt <= 16'h0000;
			prebias <= 16'h0000;
			pwmEnable <= 1'b0;
		end
		else if (shutNow && state != S_IDLE && state != S_OFF)
		begin
			// pulse output dropped in the same cycle
			state <= S_OFF;
			pwmEnable <= 1'b0;
		end
		else
			case (state)
				S_IDLE:
				begin
					pwmEnable <= 1'b0;
					refAcc <= {voutMeas, 16'h0000};
					if (goOn)
					begin
						state <= S_DELAY;
						delayCnt <= 16'h0000;
						prebias <= voutMeas;
						// planned ramp starts at zero despite pre-bias
						refAcc <= 32'h0000_0000;
					end
				end
				S_DELAY:
					if (!railOn)
						state <= S_IDLE;
					// wait the turn-on delay in ramp ticks
					else if (delayCnt >= cfg[CFG_TON_DELAY])
						state <= S_RISE;
					else if (rampTick)
						delayCnt <= delayCnt + 16'h0001;
				S_RISE:
				begin
					// enable at pre-bias level with duty above minimum
					if (refNow >= prebias && refNow > minRef)
						pwmEnable <= 1'b1;
					if (stopReq)
						state <= S_FALL;
					else if (rampTick && !divBusy)
					begin
						// saturation steps reference to cut the error
						if (errSatPos)
							refAcc <= (refAcc > stepRise) ?
								refAcc - stepRise : 32'h0000_0000;
						else if (errSatNeg)
							refAcc <= satUp[32] ? 32'hffff_ffff : satUp[31:0];
						// ramp continues from the adjusted set point
						else if (riseSum >= {1'b0, targetQ})
						begin
							refAcc <= targetQ;
							state <= S_REGULATE;
						end
						else
							refAcc <= riseSum[31:0];
					end
				end
				S_REGULATE:
				begin
					pwmEnable <= 1'b1;
					if (stopReq)
						state <= S_FALL;
					else if (rampTick)
					begin
						// foldback holds current at the limit
						if (foldActive)
							refAcc <= (refAcc > FOLD_STEP) ?
								refAcc - FOLD_STEP : 32'h0000_0000;
						else if (refAcc + FOLD_STEP < targetQ)
							refAcc <= refAcc + FOLD_STEP;
						else
							refAcc <= targetQ;
					end
				end
				S_FALL:
					// continue responses let the soft stop finish
					if (rampTick && !divBusy)
					begin
						if (errSatNeg)
							refAcc <= satUp[32] ? 32'hffff_ffff : satUp[31:0];
						// end of fall disables pulses and idles
						else if (refAcc <= stepFall)
						begin
							refAcc <= 32'h0000_0000;
							pwmEnable <= 1'b0;
							state <= S_IDLE;
						end
						else
							refAcc <= refAcc - stepFall;
					end
				S_OFF:
				begin
					pwmEnable <= 1'b0;
					refAcc <= 32'h0000_0000;
					if (!railOn)
						state <= S_IDLE;
				end
				default:
				begin
					state <= S_IDLE;
					pwmEnable <= 1'b0;
				end
			endcase

	// Reference output and loop gain bank selection
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			refDac <= 16'h0000;
			gainBank <= BANK_RAMP;
		end
		else
		begin
			// Hold pre-bias level until the planned ramp passes it
			if ((state == S_DELAY || state == S_RISE) && !pwmEnable &&
				refNow < prebias)
				refDac <= prebias;
			else
				refDac <= refNow;
			if (state != S_REGULATE)
				gainBank <= BANK_RAMP;
			else if (ioutMeas < cfg[CFG_LIGHT_LOAD])
				gainBank <= BANK_LIGHT;
			else
				gainBank <= BANK_NORMAL;
		end

	// Status events, sticky until written with a one
	always_comb
	begin
		statusSet = '0;
		statusSet[ST_VIN_OV] = ovFault;
		statusSet[ST_VIN_UV] = uvFault;
		statusSet[ST_FOLDBACK] = foldActive;
		// low output during foldback is a fault event
		statusSet[ST_OC_LV] = ocLvTrip;
		statusSet[ST_OVER_TEMP] = overTemp;
	end

	// Set beats a clear arriving in the same cycle
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			status <= '0;
		else if (busWr && busAddr == REG_STATUS)
			status <= (status & ~busWrData[STATUS_BITS-1:0]) | statusSet;
		else
			status <= status | statusSet;

	// Configuration writes
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			for (int i = 0; i < CFG_COUNT; i++)
				cfg[i] <= CFG_RST[i];
		end
		else if (busWr && busAddr < REG_CFG_END && busAddr[1:0] == 2'b00)
			cfg[busAddr[5:2]] <= busWrData[15:0];

	// Register reads, data valid the cycle after the strobe
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			busRdData <= 32'h0000_0000;
		else if (!busRd || busAddr[1:0] != 2'b00)
			busRdData <= 32'h0000_0000;
		else if (busAddr < REG_CFG_END)
			busRdData <= {16'h0000, cfg[busAddr[5:2]]};
		else if (busAddr >= REG_AUX0 && busAddr <= REG_AUX3)
			busRdData <= {16'h0000, mon.auxAvg[busAddr[3:2]]};
		else
			case (busAddr)
				REG_STATUS: busRdData <= 32'(status);
				REG_STATE: busRdData <= {26'h0, gainBank, pwmEnable, state};
				REG_VIN: busRdData <= {16'h0000, vinScaled};
				REG_REF: busRdData <= {16'h0000, refDac};
				REG_DUTY: busRdData <= {16'h0000, startDuty};
				REG_TEMP0: busRdData <= {16'h0000, mon.tempSmooth[0]};
				REG_TEMPERATURE_INPUT_ONE: busRdData <= {16'h0000, mon.tempSmooth[1]};
				default: busRdData <= 32'h0000_0000;
			endcase

endmodule // rrs_supervisor
`default_nettype wire

// *** tb/rrs_supervisor_assertions.sv ***
// Port assertions for the rail ramp supervisor
`timescale 1ns/1ps
`default_nettype none
module rrs_supervisor_assertions (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] busAddr,
	input wire logic [31:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	input wire logic [31:0] busRdData,
	input wire logic [3:0][rrs_pkg::ADC_BITS-1:0] auxCode,
	input wire logic [15:0] ioutMeas,
	input wire logic [15:0] voutMeas,
	input wire logic errSatPos,
	input wire logic errSatNeg,
	input wire logic pwmEnable,
	input wire logic [15:0] refDac,
	input wire rrs_pkg::rrs_bank_t gainBank,
	input wire logic [15:0] startDuty
);
	import rrs_pkg::*;
	logic [15:0] ocLim;
	logic [15:0] foldRef;
	logic [13:0] foldCnt;
	logic overCur;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// Overcurrent while switching, against a copy of the limit
	assign overCur = pwmEnable && ioutMeas > ocLim;

	// Limit copy and length of the current overcurrent spell
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ocLim <= CFG_RST[CFG_OC_LIMIT];
			foldRef <= 16'h0000;
			foldCnt <= 14'h0000;
		end
		else
		begin
			if (busWr && busAddr == 8'(CFG_OC_LIMIT * 4))
				ocLim <= busWrData[15:0];
			if (!overCur)
			begin
				foldCnt <= 14'h0000;
				foldRef <= refDac;
			end
			else if (foldCnt != 14'h3fff)
				foldCnt <= foldCnt + 14'h0001;
		end
	end

	a_read_gap: assert property (
		!$past(busRd) |-> busRdData == 32'h0)
		else $error("Read data outside its slot");
	a_bad_addr: assert property (
		$past(busRd) && ($past(busAddr) > REG_TEMPERATURE_INPUT_ONE
		|| $past(busAddr[1:0]) != 2'b00) |-> busRdData == 32'h0)
		else $error("Unmapped read returned data");
	a_ref_view: assert property (
		$past(busRd) && $past(busAddr) == REG_REF
		|-> busRdData == {16'h0, $past(refDac)})
		else $error("Reference readback differs");
	a_duty_view: assert property (
		$past(busRd) && $past(busAddr) == REG_DUTY
		|-> busRdData == {16'h0, $past(startDuty)})
		else $error("Start duty readback differs");
	a_state_view: assert property (
		$past(busRd) && $past(busAddr) == REG_STATE
		|-> busRdData[5:3] == {$past(gainBank), $past(pwmEnable)})
		else $error("State readback differs");
	a_fold_hold: assert property (
		overCur [*2] |=> refDac <= $past(refDac))
		else $error("Reference rose during overcurrent");
	a_fold_lower: assert property (
		foldCnt == 14'h2008 |-> refDac < foldRef)
		else $error("Reference not lowered by overcurrent");
	a_bias_first: assert property (
		$rose(pwmEnable) |-> refDac >= $past(voutMeas))
		else $error("Switching began below the pre-bias");

	c_pwm_on: cover property ($rose(pwmEnable));
	c_pwm_off: cover property ($fell(pwmEnable));
	c_fold: cover property (foldCnt == 14'h2008);
endmodule // rrs_supervisor_assertions

bind rrs_supervisor rrs_supervisor_assertions i_chk (.sys_clk, .nrst,
	.busAddr, .busWrData, .busWr, .busRd, .busRdData, .auxCode, .ioutMeas,
	.voutMeas, .errSatPos, .errSatNeg, .pwmEnable, .refDac, .gainBank,
	.startDuty);
`default_nettype wire

// *** tb/rrs_stage_model.sv ***
// Behavioural power stage and sense inputs facing the supervisor
`timescale 1ns/1ps
`default_nettype none
module rrs_stage_model (
	input wire logic pwmEnable,
	input wire logic [15:0] refDac,
	input wire logic [rrs_pkg::ADC_BITS-1:0] vinCode,
	input wire logic [15:0] preBias,
	input wire logic [15:0] loadCur,
	input wire logic satHold,
	output logic [3:0][rrs_pkg::ADC_BITS-1:0] auxCode,
	output logic [15:0] voutMeas,
	output logic [15:0] ioutMeas,
	output logic errSatPos,
	output logic errSatNeg
);
	import rrs_pkg::*;
	// Output follows the reference only while switching
	assign voutMeas = pwmEnable ? refDac : preBias;
	assign ioutMeas = pwmEnable ? loadCur : 16'h0000;
	// Fixed temperature and tracking codes, input sense from the bench
	assign auxCode = {vinCode, 12'h345, 12'h234, 12'h123};
	// Bench can hold the error converter saturated high
	assign errSatPos = satHold;
	assign errSatNeg = 1'b0;
endmodule // rrs_stage_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the rail ramp supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rrs_pkg::*;
	logic sys_clk;
	logic nrst;
	logic [7:0] busAddr;
	logic [31:0] busWrData;
	logic busWr;
	logic busRd;
	logic [31:0] busRdData;
	logic [3:0][ADC_BITS-1:0] auxCode;
	logic [15:0] ioutMeas;
	logic [15:0] voutMeas;
	logic errSatPos;
	logic errSatNeg;
	logic pwmEnable;
	logic [15:0] refDac;
	rrs_bank_t gainBank;
	logic [15:0] startDuty;
	logic [ADC_BITS-1:0] vinCode;
	logic [15:0] preBias;
	logic [15:0] loadCur;
	logic satHold;
	logic [31:0] rd;
	longint t0;
	int mismatches;
	int checkCount;

	// Short averaging interval keeps the aux readings within the run
	rrs_supervisor #(.AVG_N(4)) i_dut (.sys_clk, .nrst, .busAddr,
		.busWrData, .busWr, .busRd, .busRdData, .auxCode, .ioutMeas,
		.voutMeas, .errSatPos, .errSatNeg, .pwmEnable, .refDac, .gainBank,
		.startDuty);
	rrs_stage_model i_stage (.pwmEnable, .refDac, .vinCode, .preBias,
		.loadCur, .satHold, .auxCode, .voutMeas, .ioutMeas, .errSatPos,
		.errSatNeg);

	// Clock at 40 MHz
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;

	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic printVerdict();
		$display("Checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic writeReg(input logic [7:0] addr, input logic [31:0] data);
		@(posedge sys_clk);
		busAddr <= addr;
		busWrData <= data;
		busWr <= 1'b1;
		@(posedge sys_clk);
		busWr <= 1'b0;
	endtask

	task automatic readReg(input logic [7:0] addr);
		@(posedge sys_clk);
		busAddr <= addr;
		busRd <= 1'b1;
		@(posedge sys_clk);
		busRd <= 1'b0;
		#1;
		rd = busRdData;
	endtask

	task automatic waitCycles(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Poll the state register, bounded
	task automatic waitState(input logic [2:0] code, input int limit);
		int n;
		n = 0;
		readReg(REG_STATE);
		while (rd[2:0] !== code && n < limit)
		begin
			readReg(REG_STATE);
			n++;
		end
		if (rd[2:0] !== code)
		begin
			checkVal({29'h0, rd[2:0]}, {29'h0, code});
			printVerdict();
		end
	endtask

	initial
	begin
		nrst = 1'b0;
		busAddr = 8'h00;
		busWrData = 32'h0;
		busWr = 1'b0;
		busRd = 1'b0;
		vinCode = 12'h800;
		preBias = 16'h0100;
		loadCur = 16'h0000;
		satHold = 1'b0;
		mismatches = 0;
		checkCount = 0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		// Reset values, unmapped and unaligned reads
		for (int i = 0; i < CFG_COUNT; i++)
		begin
			readReg(8'(i * 4));
			checkVal(rd, {16'h0, CFG_RST[i]});
		end
		readReg(8'h80);
		checkVal(rd, 32'h0);
		readReg(8'h06);
		checkVal(rd, 32'h0);
		// Input sense at two scale factors
		waitCycles(4100);
		readReg(REG_VIN);
		checkVal(rd, 32'h800);
		writeReg(8'h1c, 32'h2000);
		waitCycles(4100);
		readReg(REG_VIN);
		checkVal(rd, (32'h800 * 32'h2000) >> 12);
		checkVal({16'h0, refDac}, 32'h100);
		// Start with pre-bias, temperature faults left disabled
		writeReg(8'h04, 32'h400);
		writeReg(8'h08, 32'h1);
		writeReg(8'h0c, 32'h2);
		writeReg(8'h10, 32'h2);
		writeReg(8'h14, 32'h100);
		writeReg(8'h00, 32'h11);
		t0 = $time;
		waitState(S_RISE, 9000);
		checkVal({30'h0, gainBank}, {30'h0, BANK_RAMP});
		waitState(S_REGULATE, 9000);
		t0 = ($time - t0) / 25;
		checkVal({31'h0, t0 > 7990 && t0 < 16200}, 32'h1);
		checkVal({16'h0, refDac}, 32'h400);
		checkVal({30'h0, gainBank}, {30'h0, BANK_NORMAL});
		checkVal({31'h0, pwmEnable}, 32'h1);
		checkVal({16'h0, startDuty}, 32'h1000);
		readReg(REG_REF);
		checkVal(rd, 32'h400);
		readReg(REG_DUTY);
		checkVal(rd, 32'h1000);
		// Foldback, then low-voltage shutdown
		@(posedge sys_clk);
		loadCur <= 16'h0200;
		waitCycles(8300);
		checkVal({31'h0, refDac < 16'h400}, 32'h1);
		writeReg(8'h18, 32'h400);
		waitState(S_OFF, 4000);
		checkVal({31'h0, pwmEnable}, 32'h0);
		readReg(REG_STATUS);
		checkVal(rd & 32'hc, 32'hc);
		@(posedge sys_clk);
		loadCur <= 16'h0000;
		writeReg(8'h14, 32'hffff);
		writeReg(8'h18, 32'h0);
		writeReg(8'h00, 32'h0);
		waitState(S_IDLE, 100);
		writeReg(REG_STATUS, 32'h1f);
		readReg(REG_STATUS);
		checkVal(rd, 32'h0);
		// Averaged aux words: 12-bit code scaled linearly to 16 bits
		for (int i = 0; i < AUX_CHANNELS; i++)
		begin
			readReg(REG_AUX0 + 8'(i * 4));
			checkVal(rd, {16'h0, auxCode[i], 4'h0});
		end
		readReg(REG_TEMP0);
		checkVal({31'h0, rd != 32'h0 && rd < 32'h1230}, 32'h1);
		// Soft stop from low input, continue response
		writeReg(8'h00, 32'h01);
		waitState(S_REGULATE, 9000);
		writeReg(8'h2c, 32'h1001);
		writeReg(8'h24, 32'h1001);
		waitState(S_FALL, 50);
		checkVal({31'h0, pwmEnable}, 32'h1);
		checkVal({30'h0, gainBank}, {30'h0, BANK_RAMP});
		waitState(S_IDLE, 9000);
		checkVal({31'h0, pwmEnable}, 32'h0);
		readReg(REG_STATUS);
		checkVal(rd & 32'h2, 32'h2);
		checkVal({16'h0, refDac}, 32'h100);
		// Immediate shutdown on input undervoltage
		writeReg(8'h00, 32'h05);
		writeReg(8'h2c, 32'h0);
		writeReg(8'h24, 32'h0);
		// Saturation for one tick pulls the reference back down
		waitState(S_RISE, 9000);
		waitCycles(4100);
		@(posedge sys_clk);
		satHold <= 1'b1;
		waitCycles(3999);
		@(posedge sys_clk);
		satHold <= 1'b0;
		waitCycles(2);
		checkVal({16'h0, refDac}, 32'h0);
		waitState(S_REGULATE, 9000);
		writeReg(8'h24, 32'h1001);
		waitCycles(2);
		checkVal({31'h0, pwmEnable}, 32'h0);
		waitState(S_OFF, 20);
		printVerdict();
	end
endmodule // tb
`default_nettype wire
